/* File: logic/sai_pkg.sv */
// Constants for the serial audio input port: register map, fields, timing.
// Assumes an APB master on pclk and an external serial master driving the link.
package sai_pkg;
   // ==========================================
   // Register map (byte addresses)
   localparam logic [11:0] SAI_CFG_ADDR = 12'h000;
   localparam logic [11:0] SAI_LEFT_ADDR = 12'h004;
   localparam logic [11:0] SAI_RIGHT_ADDR = 12'h008;
   localparam logic [11:0] SAI_STAT_ADDR = 12'h00c;
   // ==========================================
   // Configuration register fields
   localparam int SAI_FMT_LSB = 0;
   localparam int SAI_FMT_W = 4;
   localparam int SAI_ORDER_BIT = 4;
   localparam int SAI_DELAY_BIT = 5;
   localparam int SAI_MAP1_BIT = 6;
   localparam int SAI_MAP2_BIT = 7;
   localparam logic [7:0] SAI_CFG_RESET = 8'h80;
   // Formats: I2S (one-bit delay) and left-justified (no delay)
   localparam logic [3:0] SAI_FMT_I2S = 4'h0;
   localparam logic [3:0] SAI_FMT_LJ = 4'h1;
   // Status fields
   localparam int SAI_STAT_LVALID = 0;
   localparam int SAI_STAT_RVALID = 1;
   localparam int SAI_STAT_OVR = 2;
   // ==========================================
   // Timing
   localparam int SAI_CLK_MHZ = 100;
   localparam int SAI_BCK_MIN_NS = 80;
   localparam int SAI_BCK_MIN_CYC = (SAI_BCK_MIN_NS * SAI_CLK_MHZ + 999) / 1000;
   localparam int SAI_WORD_W = 24;
endpackage : sai_pkg

/* File: logic/sai_rx.sv */
// Serial audio input port: link slave receiver with APB registers.
// Words go to a two-entry stream buffer and to per-channel registers.
// Assumes link clocks are asynchronous to pclk and slower than pclk/4.
// Link pins arrive from another clock domain.
`timescale 1ns/1ps
`default_nettype none
module sai_rx
   import sai_pkg::*;
#(
   parameter int WORD_W = SAI_WORD_W
)
(
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial link, all inputs
   input wire logic bit_clock_in,
   input wire logic frame_clock_in,
   input wire logic serial_audio_in,
   // Sample stream to processing channels
   output logic samp_valid,
   input wire logic samp_ready,
   output logic samp_chan,
   output logic [WORD_W-1:0] samp_data
);
   // ==========================================
   // Parameter check
   generate
      if (WORD_W < 8 || WORD_W > 32)
      begin : g_word_w_bad
         $error("sai_rx: WORD_W out of range");
      end
   endgenerate

   // ==========================================
   // Synchronisers
   // Link pins change off pclk; two flops before any use
   logic [1:0] bck_sync_reg;
   logic [1:0] lrck_sync_reg;
   logic [1:0] sdi_sync_reg;
   logic bck_dly_reg;
   logic bck_prev_reg;
   logic [7:0] cfg_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bck_sync_reg <= 2'b00;
         lrck_sync_reg <= 2'b00;
         sdi_sync_reg <= 2'b00;
      end
      else
      begin
         bck_sync_reg <= {bck_sync_reg[0], bit_clock_in};
         lrck_sync_reg <= {lrck_sync_reg[0], frame_clock_in};
         sdi_sync_reg <= {sdi_sync_reg[0], serial_audio_in};
      end
   end

   // Optional one-clock delay of the bit clock
   wire bck_delay_en = cfg_reg[SAI_DELAY_BIT];
   wire bck_eff = bck_delay_en ? bck_dly_reg : bck_sync_reg[1];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bck_dly_reg <= 1'b0;
      else
         bck_dly_reg <= bck_sync_reg[1];
   end

   // Previous level of the selected bit clock, for edge finding
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bck_prev_reg <= 1'b0;
      else
         bck_prev_reg <= bck_eff;
   end

   // Rising bit clock is the strobing edge
   // Frame clock is taken at the same strobe as the data bit
   wire strobe = bck_eff && !bck_prev_reg;
   wire lrck_now = lrck_sync_reg[1];
   wire sdi_now = sdi_sync_reg[1];

   // ==========================================
   // Deserialiser
   logic lrck_last_reg;
   logic frame_seen_reg;
   logic [5:0] bit_cnt_reg;
   logic [WORD_W-1:0] shift_reg;
   logic cur_chan_reg;

   wire [3:0] input_format_select = cfg_reg[SAI_FMT_LSB +: SAI_FMT_W];
   wire first_bit_order = cfg_reg[SAI_ORDER_BIT];
   wire is_i2s = (input_format_select == SAI_FMT_I2S);
   // A frame clock change at a strobe closes the word in progress
   // Frame level 0 is channel 0, level 1 channel 1
   wire frame_edge = strobe && (lrck_now != lrck_last_reg);
   wire [5:0] word_w6 = 6'(WORD_W);
   wire bit_take = strobe && !frame_edge && frame_seen_reg && (bit_cnt_reg < word_w6);
   wire bit_take_first = frame_edge && !is_i2s;
   // LSB-first shifts right from the top, MSB-first shifts left
   wire [WORD_W-1:0] shift_msb = {shift_reg[WORD_W-2:0], sdi_now};
   wire [WORD_W-1:0] shift_lsb = {sdi_now, shift_reg[WORD_W-1:1]};
   wire [WORD_W-1:0] shift_next = first_bit_order ? shift_lsb : shift_msb;
   wire [WORD_W-1:0] shift_first_msb = {{(WORD_W-1){1'b0}}, sdi_now};
   wire [WORD_W-1:0] shift_first_lsb = {sdi_now, {(WORD_W-1){1'b0}}};
   wire [WORD_W-1:0] shift_first = first_bit_order ? shift_first_lsb : shift_first_msb;
   // Left-justify a short LSB-first word is not needed: word is full width
   wire word_done = frame_edge;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lrck_last_reg <= 1'b0;
         bit_cnt_reg <= 6'h00;
         shift_reg <= '0;
         cur_chan_reg <= 1'b0;
      end
      else if (frame_edge)
      begin
         lrck_last_reg <= lrck_now;
         cur_chan_reg <= lrck_now;
         bit_cnt_reg <= bit_take_first ? 6'h01 : 6'h00;
         shift_reg <= bit_take_first ? shift_first : '0;
      end
      else if (bit_take)
      begin
         bit_cnt_reg <= bit_cnt_reg + 6'h01;
         shift_reg <= shift_next;
      end
   end

   // No bits are taken before the first frame edge after reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         frame_seen_reg <= 1'b0;
      else if (frame_edge)
         frame_seen_reg <= 1'b1;
   end

   // ==========================================
   // Channel mapping and two-entry buffer
   wire map1 = cfg_reg[SAI_MAP1_BIT];
   wire map2 = cfg_reg[SAI_MAP2_BIT];
   // Map bit holds the destination channel index
   wire mapped_chan = cur_chan_reg ? map2 : map1;
   // LSB-first words land in the top bits; a short one is passed on there, not brought down
   wire [WORD_W-1:0] word_out = shift_reg;
   wire push = word_done && (bit_cnt_reg != 6'h00);

   logic [WORD_W:0] buf_mem [0:1];
   logic buf_wp_reg;
   logic buf_rp_reg;
   logic [1:0] buf_cnt_reg;
   logic ovr_reg;
   wire buf_full = (buf_cnt_reg == 2'd2);
   wire buf_empty = (buf_cnt_reg == 2'd0);
   // Full buffer still takes a word if one leaves in the same cycle
   wire do_pop = samp_valid && samp_ready;
   wire do_push = push && (!buf_full || do_pop);

   // Memory needs no reset: nothing reads it while empty
   always_ff @(posedge pclk)
   begin
      if (do_push)
         buf_mem[buf_wp_reg] <= {mapped_chan, word_out};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         buf_wp_reg <= 1'b0;
      else if (do_push)
         buf_wp_reg <= ~buf_wp_reg;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         buf_rp_reg <= 1'b0;
      else if (do_pop)
         buf_rp_reg <= ~buf_rp_reg;
   end

   // Occupancy: push and pop in one cycle leave it unchanged
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         buf_cnt_reg <= 2'd0;
      else
         buf_cnt_reg <= 2'(buf_cnt_reg + {1'b0, do_push} - {1'b0, do_pop});
   end

   assign samp_valid = !buf_empty;
   assign samp_chan = buf_mem[buf_rp_reg][WORD_W];
   assign samp_data = buf_mem[buf_rp_reg][WORD_W-1:0];

   // ==========================================
   // APB slave, zero wait states
   logic [WORD_W-1:0] left_reg;
   logic [WORD_W-1:0] right_reg;
   logic lvalid_reg;
   logic rvalid_reg;

   // Exact match of one register's byte address
   function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] base);
      return addr == base;
   endfunction : addr_is

   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire hit_cfg = addr_is(paddr, SAI_CFG_ADDR);
   wire hit_left = addr_is(paddr, SAI_LEFT_ADDR);
   wire hit_right = addr_is(paddr, SAI_RIGHT_ADDR);
   wire hit_stat = addr_is(paddr, SAI_STAT_ADDR);
   // Unmapped offsets answer with an error, writes ignored
   wire hit_any = hit_cfg || hit_left || hit_right || hit_stat;
   wire [31:0] rd_mux =
      hit_cfg ? {24'h000000, cfg_reg} :
      hit_left ? 32'(left_reg) :
      hit_right ? 32'(right_reg) :
      hit_stat ? {29'h0, ovr_reg, rvalid_reg, lvalid_reg} : 32'h00000000;

   // Flag events; a word that finds no room is lost and flagged
   wire got_l = do_push && !mapped_chan;
   wire got_r = do_push && mapped_chan;
   wire ovr_set = push && !do_push;
   wire left_read = rd && hit_left;
   wire right_read = rd && hit_right;
   wire ovr_clear = wr && hit_stat && pwdata[SAI_STAT_OVR];
   wire lvalid_next = got_l || (lvalid_reg && !left_read);
   wire rvalid_next = got_r || (rvalid_reg && !right_read);
   wire ovr_next = ovr_set || (ovr_reg && !ovr_clear);

   // ==========================================
   // Configuration register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_reg <= SAI_CFG_RESET;
      else if (wr && hit_cfg)
         cfg_reg <= pwdata[7:0];
   end

   // Latest word per processing channel
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         left_reg <= '0;
         right_reg <= '0;
      end
      else
      begin
         if (got_l)
            left_reg <= word_out;
         if (got_r)
            right_reg <= word_out;
      end
   end

   // Sticky flags; set wins over clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lvalid_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         ovr_reg <= 1'b0;
      end
      else
      begin
         lvalid_reg <= lvalid_next;
         rvalid_reg <= rvalid_next;
         ovr_reg <= ovr_next;
      end
   end

   // Reads return zero outside a read access
   assign prdata = rd ? rd_mux : 32'h00000000;
   assign pready = 1'b1;
   assign pslverr = acc && !hit_any;
   // No clock outputs exist: the link is receive-only slave.
endmodule : sai_rx
`default_nettype wire

/* File: tb/sai_rx_props.sv */
// Port checker for sai_rx, bound below.
// Assumes a legal APB master and link source.
`timescale 1ns/1ps
`default_nettype none
module sai_rx_props
   import sai_pkg::*;
#(
   parameter int WORD_W = SAI_WORD_W
)
(
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Stream
   input wire logic samp_valid,
   input wire logic samp_ready,
   input wire logic samp_chan,
   input wire logic [WORD_W-1:0] samp_data
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic acc = psel && penable;
   wire logic rd = acc && !pwrite;
   // ==========
   // Bus answers
   property p_rdy; pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready low");
   property p_idle; !acc |-> !pslverr && prdata == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("idle answer");
   property p_wr; acc && pwrite |-> prdata == 32'h0; endproperty
   a_wr: assert property (p_wr) else $error("data on write");
   property p_bad; acc && paddr > SAI_STAT_ADDR |-> pslverr && prdata == 32'h0; endproperty
   a_bad: assert property (p_bad) else $error("unmapped kept");
   property p_ok; acc && paddr <= SAI_STAT_ADDR && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
   a_ok: assert property (p_ok) else $error("mapped refused");
   property p_cfg; rd && paddr == SAI_CFG_ADDR |-> prdata[31:8] == 24'h0; endproperty
   a_cfg: assert property (p_cfg) else $error("config width");
   property p_stat; rd && paddr == SAI_STAT_ADDR |-> prdata[31:3] == 29'h0; endproperty
   a_stat: assert property (p_stat) else $error("status width");
   // ==========
   // Stream
   property p_hold;
      samp_valid && !samp_ready |=> samp_valid && $stable(samp_data) && $stable(samp_chan);
   endproperty
   a_hold: assert property (p_hold) else $error("word not held");
   c_push: cover property (samp_valid && samp_ready);
   c_full: cover property ((samp_valid && !samp_ready) [*8]);
   c_bad: cover property (acc && pslverr);
endmodule : sai_rx_props
bind sai_rx sai_rx_props #(.WORD_W(WORD_W)) sai_rx_props_i (.*);
`default_nettype wire

/* File: tb/sai_src.sv */
// Link master model: one frame per rising go.
// Bit clock 80 ns, still between frames.
`timescale 1ns/1ps
`default_nettype none
module sai_src
(
   // Frame request
   input wire logic go,
   input wire logic lsb,
   input wire logic lj,
   input wire logic [23:0] lw,
   input wire logic [23:0] rw,
   // Link
   output logic bit_clock_in,
   output logic frame_clock_in,
   output logic serial_audio_in
);
   logic [23:0] w;
   int k;
   initial {bit_clock_in, frame_clock_in, serial_audio_in} = 3'b000;
   always @(posedge go)
   begin
      for (int i = 0; i < 50; i++)
      begin
         w = i < 25 ? lw : rw;
         k = i % 25 - (lj ? 0 : 1);
         frame_clock_in = i > 24;
         serial_audio_in = (k < 0 || k > 23) ? ~serial_audio_in : w[lsb ? k : 23 - k];
         #40 bit_clock_in = 1'b1;
         #40 bit_clock_in = 1'b0;
      end
      serial_audio_in = ~serial_audio_in;
   end
endmodule : sai_src
`default_nettype wire

/* File: tb/sai_rx_tb.sv */
// Bench for sai_rx: APB tasks, link source, word monitor.
// Checker comes by bind.
`timescale 1ns/1ps
`default_nettype none
module sai_rx_tb;
   import sai_pkg::*;
   localparam logic [7:0] CFGS [7] = '{8'h80, 8'h90, 8'h81, 8'h91, 8'h40, 8'hc0, 8'ha0};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic go = 1'b0, samp_ready = 1'b1, lsb = 1'b0, lj = 1'b0, er;
   logic pready, pslverr, bit_clock_in, frame_clock_in, serial_audio_in, samp_valid, samp_chan;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [23:0] samp_data, lw = 24'h0, rw = 24'h0, pend = 24'h0;
   logic [7:0] cfg = SAI_CFG_RESET;
   logic [25:0] q[$];
   int failures = 0, n_compared = 0, cyc = 0;
   always #5 pclk = ~pclk;
   sai_src sai_src_i (.*);
   sai_rx sai_rx_i (.*);
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e)
      begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   // Expect pending right word then this left word; full buffer drops
   task automatic send(input logic [23:0] l, input logic [23:0] r, input logic c);
      if (q.size() < 2)
         q.push_back({c, cfg[SAI_MAP2_BIT], pend});
      if (q.size() < 2)
         q.push_back({c, cfg[SAI_MAP1_BIT], l});
      pend = r;
      {lw, rw, lsb, lj} <= {l, r, cfg[SAI_ORDER_BIT], cfg[SAI_FMT_LSB]};
      @(posedge pclk);
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (410) @(posedge pclk);
   endtask : send
   task automatic give_verdict();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   always @(posedge pclk)
   begin
      cyc++;
      if (samp_valid === 1'b1 && samp_ready === 1'b1 && q.size() > 0)
      begin
         if (q[0][25] === 1'b1)
            chk("word", 32'(q[0][24:0]), {7'h0, samp_chan, samp_data});
         q.delete(0);
      end
      if (cyc == 15000)
      begin
         failures++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, SAI_CFG_ADDR, 32'h0);
      chk("cfg", 32'h80, rd);
      send(24'h0, 24'h0, 1'b0);
      q.delete();
      for (int i = 0; i < 7; i++)
      begin
         cfg = CFGS[i];
         apb(1'b1, SAI_CFG_ADDR, {24'h0, cfg});
         send(24'h0, 24'h0, 1'b0);
         send(24'h8421f0, 24'h0d5ab3, 1'b1);
         send(24'h7bde0f, 24'hf2a54c, 1'b1);
      end
      samp_ready <= 1'b0;
      send(24'h000001, 24'h800000, 1'b1);
      send(24'h555555, 24'haaaaaa, 1'b1);
      apb(1'b0, SAI_STAT_ADDR, 32'h0);
      chk("overflow", 32'h1, 32'(rd[SAI_STAT_OVR]));
      apb(1'b1, SAI_STAT_ADDR, 32'h4);
      apb(1'b0, SAI_STAT_ADDR, 32'h0);
      chk("overflow", 32'h0, 32'(rd[SAI_STAT_OVR]));
      chk("status", 32'h3, rd);
      apb(1'b0, 12'h100, 32'h0);
      chk("unmapped", 32'h1, 32'(er));
      apb(1'b0, SAI_LEFT_ADDR, 32'h0);
      chk("left", 32'h000001, rd);
      apb(1'b0, SAI_RIGHT_ADDR, 32'h0);
      chk("right", 32'hf2a54c, rd);
      apb(1'b0, SAI_STAT_ADDR, 32'h0);
      chk("status", 32'h0, rd);
      samp_ready <= 1'b1;
      repeat (10) @(posedge pclk);
      chk("pending", 32'h0, 32'(q.size()));
      give_verdict();
   end
endmodule : sai_rx_tb
`default_nettype wire
